// [pbr_consts.svh]
// Functional notes
// - Start head read only after earlier posted writes drain; reuse captured address, command.
// - Nonprefetchable read drives captured byte enables; prefetchable drives all zero.
// - On target retry, reissue the same read until data moves or error.
// - After data moved, master completion or disconnect ends fetching for that entry.
// - After the attempt limit, stop, drop entry, target-abort the repeated request.
// - Giving up raises system error only when its enable is set.
// - Data taken on DEVSEL and TRDY goes to the queue facing the initiator.
// - Accept one Dword every clock, no master wait states.
// - Return data only on repeat, target done, head of queue, ordering satisfied.
// - Memory read, read line and read multiple alias when matching repeats.
// - Disconnect with the last Dword; early initiator stop discards leftover data.
// - Repeat taking prefetched data while target read runs enters flow-through.
// - Flow-through runs until initiator stop, 4 KB boundary, or buffer full.
// - Flow-through holds TRDY off only while the buffer is empty; code also holds it off while the last Dword before a 4 KB boundary is fetched.
// - Initiator ending flow-through ends the target read and discards data.
// - Discard timer starts at completion head; two initial values by timeout select.
// - Timer expiry without repeat drops entry and data, conditional system error.
// - At most three pending reads; duplicate address and command is not posted.
// - Config address bits 1:0 of 00b is Type 0, 01b is Type 1.
// - Primary Type 0 with ID-select asserted is claimed; function number ignored.
// - Own config access is one Dword, disconnect first transfer, no buffers.
// - Type 0 config from the secondary side is never claimed.
// - Non-flow prefetch stops at 1, 16 Dword or cache line (two lines for read multiple) boundaries; read multiple with invalid line size stops only at buffer full.
`ifndef PBR_CONSTS_SVH
`define PBR_CONSTS_SVH
`define PBR_CMD_MEM_RD  4'h6
`define PBR_CMD_MRL     4'he
`define PBR_CMD_MRM     4'hc
`define PBR_CMD_CFG_RD  4'ha
`define PBR_CMD_CFG_WR  4'hb
`define PBR_CFG_TYPE0   2'h0
`define PBR_CFG_TYPE1   2'h1
`define PBR_BND_16DW    11'h010
`define PBR_BND_4KB     11'h400
`define PBR_BND_ONE     11'h001
`define PBR_BE_ALL      4'h0
`define PBR_BUS_MSB     23
`define PBR_BUS_LSB     16
`define PBR_DEV_MSB     15
`define PBR_DEV_LSB     11
`endif

// [pbr_pkg.sv]
package pbr_pkg;
   typedef enum logic [2:0] {S_IDLE, S_ADDR, S_DATA, S_DONE, S_ABORT} pbr_state_t;
endpackage

// [pbr_delayed_read.sv]
`timescale 1ns/1ps
`include "pbr_consts.svh"
module pbr_delayed_read #(
   parameter int          QDEPTH     = 3,
   parameter int          BUFD       = 8,
   parameter int unsigned MAX_TRIES  = 2**24,
   parameter int unsigned DISC_LONG  = 32768,
   parameter int unsigned DISC_SHORT = 1024
) (
   input  wire logic        sys_clk,
   input  wire logic        reset_n,
   input  wire logic        new_valid,
   input  wire logic [31:0] new_addr,
   input  wire logic [3:0]  new_cmd,
   input  wire logic [3:0]  new_be,
   input  wire logic        new_pref,
   output logic             new_posted_ff,
   output logic             new_dup_ff,
   output logic             new_full_ff,
   input  wire logic        posted_empty,
   input  wire logic        order_ok,
   input  wire logic [7:0]  cls,
   input  wire logic        serr_en,
   input  wire logic        tmo_short,
   input  wire logic        tgt_devsel,
   input  wire logic        tgt_trdy,
   input  wire logic        tgt_retry,
   input  wire logic        tgt_stop,
   input  wire logic        tgt_err,
   input  wire logic [31:0] tgt_data,
   output logic             tgt_frame_ff,
   output logic             tgt_addr_phase_ff,
   output logic [31:0]      tgt_addr_ff,
   output logic [3:0]       tgt_cmd_ff,
   output logic [3:0]       tgt_be_ff,
   input  wire logic        ini_valid,
   input  wire logic [31:0] ini_addr,
   input  wire logic [3:0]  ini_cmd,
   input  wire logic        ini_last,
   output logic             ini_trdy_ff,
   output logic [31:0]      ini_data_ff,
   output logic             ini_stop_ff,
   output logic             ini_retry_ff,
   output logic             ini_abort_ff,
   output logic             flow_ff,
   output logic             serr_ff,
   input  wire logic        cfg_valid,
   input  wire logic [3:0]  cfg_cmd,
   input  wire logic [31:0] cfg_addr,
   input  wire logic        cfg_idsel,
   input  wire logic        cfg_secondary,
   output logic             cfg_devsel_ff,
   output logic             cfg_stop_ff,
   output logic             cfg_type1_ff,
   output logic [7:0]       cfg_bus_ff,
   output logic [4:0]       cfg_dev_ff
);
   localparam int BW = $clog2(BUFD + 1);
   localparam int PW = $clog2(BUFD);
   localparam int QW = $clog2(QDEPTH + 1);
   localparam int DW = $clog2(DISC_LONG + 1);

   function automatic logic is_mrd(input logic [3:0] c);
      return c == `PBR_CMD_MEM_RD || c == `PBR_CMD_MRL || c == `PBR_CMD_MRM;
   endfunction
   function automatic logic cmd_eq(input logic [3:0] a, input logic [3:0] b);
      return (a == b) || (is_mrd(a) && is_mrd(b));
   endfunction

   pbr_pkg::pbr_state_t state_ff, nxt_state;
   logic [31:0] q_addr_ff [QDEPTH];
   logic [3:0]  q_cmd_ff  [QDEPTH];
   logic [3:0]  q_be_ff   [QDEPTH];
   logic        q_pref_ff [QDEPTH];
   logic [QW-1:0] q_cnt_ff;
   logic [31:0] buf_ff [BUFD];
   logic [PW-1:0] wp_ff, rp_ff;
   logic [BW-1:0] cnt_ff;
   logic [24:0] tries_ff;
   logic [DW-1:0] disc_ff;
   logic [31:0] fetch_ff;
   logic        got_ff, started_ff;
   logic [QDEPTH-1:0] dup_hit;

   // Duplicate check looks at the exact command, aliasing is only for repeats
   for (genvar g = 0; g < QDEPTH; g++) begin : g_dup
      assign dup_hit[g] = (QW'(g) < q_cnt_ff) && q_addr_ff[g] == new_addr
                          && q_cmd_ff[g] == new_cmd;
   end

   logic [10:0] bound;
   logic        pow2_cls, rep_match, hit_bnd, push, pop, clr, deliver, giveup, expire;
   logic [31:0] nxt_q_addr [QDEPTH];
   logic [3:0]  nxt_q_cmd  [QDEPTH];
   logic [3:0]  nxt_q_be   [QDEPTH];
   logic        nxt_q_pref [QDEPTH];
   logic [QW-1:0] nxt_q_cnt, ins;
   logic [PW-1:0] nxt_wp, nxt_rp;
   logic [BW-1:0] nxt_cnt;
   logic [24:0] nxt_tries;
   logic [DW-1:0] nxt_disc;
   logic [31:0] nxt_fetch, nxt_tgt_addr, nxt_ini_data;
   logic [3:0]  nxt_tgt_cmd, nxt_tgt_be;
   logic nxt_got, nxt_started, nxt_tgt_frame, nxt_tgt_ap, nxt_ini_trdy, nxt_ini_stop;
   logic nxt_ini_retry, nxt_ini_abort, nxt_flow, nxt_serr, nxt_posted, nxt_dup, nxt_full;

   always_comb begin
      pow2_cls = cls == 8'h01 || cls == 8'h02 || cls == 8'h04 || cls == 8'h08;
      if (flow_ff)
         bound = `PBR_BND_4KB;
      else if (!q_pref_ff[0])
         bound = `PBR_BND_ONE;
      else if (pow2_cls)
         bound = (q_cmd_ff[0] == `PBR_CMD_MRM) ? {2'h0, cls, 1'b0} : {3'h0, cls};
      else
         bound = (q_cmd_ff[0] == `PBR_CMD_MRM) ? 11'h000 : `PBR_BND_16DW;
      hit_bnd = bound != 11'h000 && ((({1'b0, fetch_ff[11:2]} + 11'h001) & (bound - 11'h001))
                == 11'h000);
      rep_match = ini_valid && q_cnt_ff != '0 && ini_addr == q_addr_ff[0]
                  && cmd_eq(ini_cmd, q_cmd_ff[0]);
   end

   always_comb begin
      nxt_state = state_ff;
      nxt_tries = tries_ff;
      nxt_disc = disc_ff;
      nxt_fetch = fetch_ff;
      nxt_got = got_ff;
      nxt_started = started_ff;
      nxt_tgt_frame = tgt_frame_ff;
      nxt_tgt_addr = tgt_addr_ff;
      nxt_tgt_cmd = tgt_cmd_ff;
      nxt_tgt_be = tgt_be_ff;
      nxt_tgt_ap = 1'b0;
      nxt_ini_trdy = 1'b0;
      nxt_ini_data = ini_data_ff;
      nxt_ini_stop = 1'b0;
      nxt_ini_retry = 1'b0;
      nxt_ini_abort = 1'b0;
      nxt_flow = flow_ff;
      nxt_serr = 1'b0;
      push = 1'b0;
      pop = 1'b0;
      clr = 1'b0;
      deliver = 1'b0;
      giveup = 1'b0;
      expire = 1'b0;
      // Repeats are served from the head; flow-through only for prefetched reads
      if (rep_match && order_ok && cnt_ff != '0 && (state_ff == pbr_pkg::S_DONE
          || (state_ff == pbr_pkg::S_DATA && q_pref_ff[0] && !hit_bnd))) begin
         deliver = 1'b1;
         nxt_started = 1'b1;
         nxt_ini_trdy = 1'b1;
         nxt_ini_data = buf_ff[rp_ff];
         if (state_ff == pbr_pkg::S_DATA)
            nxt_flow = 1'b1;
      end
      unique case (state_ff)
         pbr_pkg::S_IDLE: begin
            if (q_cnt_ff != '0 && posted_empty) begin
               nxt_state = pbr_pkg::S_ADDR;
               nxt_tries = '0;
               nxt_got = 1'b0;
               nxt_started = 1'b0;
               nxt_flow = 1'b0;
            end
         end
         pbr_pkg::S_ADDR: begin
            nxt_tgt_frame = 1'b1;
            nxt_tgt_ap = 1'b1;
            nxt_tgt_addr = q_addr_ff[0];
            nxt_tgt_cmd = q_cmd_ff[0];
            nxt_tgt_be = q_pref_ff[0] ? `PBR_BE_ALL : q_be_ff[0];
            nxt_fetch = q_addr_ff[0];
            nxt_tries = tries_ff + 25'h0000001;
            nxt_state = pbr_pkg::S_DATA;
         end
         pbr_pkg::S_DATA: begin
            if (tgt_devsel && tgt_trdy) begin
               push = 1'b1;
               nxt_got = 1'b1;
               nxt_fetch = fetch_ff + 32'h4;
               // Master stop: boundary or buffer about to fill
               if (hit_bnd || (cnt_ff == BW'(BUFD - 1) && !deliver)) begin
                  nxt_tgt_frame = 1'b0;
                  nxt_state = pbr_pkg::S_DONE;
               end
            end
            if (tgt_err || (tgt_stop && (got_ff || tgt_trdy))) begin
               nxt_tgt_frame = 1'b0;
               nxt_state = pbr_pkg::S_DONE;
            end else if (tgt_retry && !got_ff) begin
               nxt_tgt_frame = 1'b0;
               if (tries_ff == 25'(MAX_TRIES)) begin
                  giveup = 1'b1;
                  nxt_serr = serr_en;
                  nxt_state = pbr_pkg::S_ABORT;
               end else begin
                  nxt_state = pbr_pkg::S_ADDR;
               end
            end
            if (flow_ff && deliver && ini_last) begin
               nxt_tgt_frame = 1'b0;
               clr = 1'b1;
               pop = 1'b1;
               nxt_state = pbr_pkg::S_IDLE;
            end
            if (nxt_state == pbr_pkg::S_DONE)
               nxt_disc = tmo_short ? DW'(DISC_SHORT) : DW'(DISC_LONG);
         end
         pbr_pkg::S_DONE: begin
            if (deliver && (cnt_ff == BW'(1) || ini_last)) begin
               nxt_ini_stop = cnt_ff == BW'(1);
               clr = 1'b1;
               pop = 1'b1;
               nxt_state = pbr_pkg::S_IDLE;
            end else if (!started_ff && !deliver) begin
               nxt_disc = disc_ff - DW'(1);
               if (disc_ff == DW'(1)) begin
                  expire = 1'b1;
                  nxt_serr = serr_en;
                  clr = 1'b1;
                  pop = 1'b1;
                  nxt_state = pbr_pkg::S_IDLE;
               end
            end
         end
         pbr_pkg::S_ABORT: begin
            if (rep_match) begin
               nxt_ini_abort = 1'b1;
               pop = 1'b1;
               nxt_state = pbr_pkg::S_IDLE;
            end
         end
      endcase
      if (ini_valid && !deliver && !nxt_ini_abort)
         nxt_ini_retry = 1'b1;
      nxt_wp = clr ? '0 : (push ? PW'(wp_ff + PW'(1)) : wp_ff);
      nxt_rp = clr ? '0 : (deliver ? PW'(rp_ff + PW'(1)) : rp_ff);
      nxt_cnt = clr ? '0 : BW'(cnt_ff + BW'(push) - BW'(deliver));
   end

   always_comb begin
      nxt_posted = 1'b0;
      nxt_dup = 1'b0;
      nxt_full = 1'b0;
      for (int i = 0; i < QDEPTH; i++) begin
         if (pop && i < QDEPTH - 1) begin
            nxt_q_addr[i] = q_addr_ff[i + 1];
            nxt_q_cmd[i] = q_cmd_ff[i + 1];
            nxt_q_be[i] = q_be_ff[i + 1];
            nxt_q_pref[i] = q_pref_ff[i + 1];
         end else begin
            nxt_q_addr[i] = q_addr_ff[i];
            nxt_q_cmd[i] = q_cmd_ff[i];
            nxt_q_be[i] = q_be_ff[i];
            nxt_q_pref[i] = q_pref_ff[i];
         end
      end
      nxt_q_cnt = pop ? QW'(q_cnt_ff - QW'(1)) : q_cnt_ff;
      ins = nxt_q_cnt;
      if (new_valid) begin
         if (dup_hit != '0)
            nxt_dup = 1'b1;
         else if (q_cnt_ff == QW'(QDEPTH))
            nxt_full = 1'b1;
         else begin
            nxt_posted = 1'b1;
            for (int i = 0; i < QDEPTH; i++) begin
               if (QW'(i) == ins) begin
                  nxt_q_addr[i] = new_addr;
                  nxt_q_cmd[i] = new_cmd;
                  nxt_q_be[i] = new_be;
                  nxt_q_pref[i] = new_pref;
               end
            end
            nxt_q_cnt = QW'(ins + QW'(1));
         end
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_ff <= pbr_pkg::S_IDLE;
         {tries_ff, disc_ff, fetch_ff, got_ff, started_ff} <= '0;
         {tgt_frame_ff, tgt_addr_phase_ff, tgt_addr_ff, tgt_cmd_ff, tgt_be_ff} <= '0;
         {ini_trdy_ff, ini_data_ff, ini_stop_ff, ini_retry_ff, ini_abort_ff} <= '0;
         {flow_ff, serr_ff, new_posted_ff, new_dup_ff, new_full_ff} <= '0;
         {wp_ff, rp_ff, cnt_ff, q_cnt_ff} <= '0;
         for (int i = 0; i < QDEPTH; i++) begin
            {q_addr_ff[i], q_cmd_ff[i], q_be_ff[i], q_pref_ff[i]} <= '0;
         end
         for (int i = 0; i < BUFD; i++) begin
            buf_ff[i] <= '0;
         end
      end else begin
         state_ff <= nxt_state;
         {tries_ff, disc_ff, fetch_ff, got_ff, started_ff} <=
            {nxt_tries, nxt_disc, nxt_fetch, nxt_got, nxt_started};
         {tgt_frame_ff, tgt_addr_phase_ff, tgt_addr_ff, tgt_cmd_ff, tgt_be_ff} <=
            {nxt_tgt_frame, nxt_tgt_ap, nxt_tgt_addr, nxt_tgt_cmd, nxt_tgt_be};
         {ini_trdy_ff, ini_data_ff, ini_stop_ff, ini_retry_ff, ini_abort_ff} <=
            {nxt_ini_trdy, nxt_ini_data, nxt_ini_stop, nxt_ini_retry, nxt_ini_abort};
         {flow_ff, serr_ff, new_posted_ff, new_dup_ff, new_full_ff} <=
            {nxt_flow, nxt_serr, nxt_posted, nxt_dup, nxt_full};
         {wp_ff, rp_ff, cnt_ff, q_cnt_ff} <= {nxt_wp, nxt_rp, nxt_cnt, nxt_q_cnt};
         for (int i = 0; i < QDEPTH; i++) begin
            {q_addr_ff[i], q_cmd_ff[i], q_be_ff[i], q_pref_ff[i]} <=
               {nxt_q_addr[i], nxt_q_cmd[i], nxt_q_be[i], nxt_q_pref[i]};
         end
         if (push)
            buf_ff[wp_ff] <= tgt_data;
      end
   end

   // Own config space: answered at once from the address phase, never buffered
   logic cfg_is, nxt_devsel, nxt_type1;
   always_comb begin
      cfg_is = cfg_valid && (cfg_cmd == `PBR_CMD_CFG_RD || cfg_cmd == `PBR_CMD_CFG_WR);
      nxt_devsel = cfg_is && cfg_addr[1:0] == `PBR_CFG_TYPE0 && cfg_idsel
                   && !cfg_secondary;
      nxt_type1 = cfg_is && cfg_addr[1:0] == `PBR_CFG_TYPE1;
   end
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         {cfg_devsel_ff, cfg_stop_ff, cfg_type1_ff, cfg_bus_ff, cfg_dev_ff} <= '0;
      end else begin
         cfg_devsel_ff <= nxt_devsel;
         cfg_stop_ff <= nxt_devsel;
         cfg_type1_ff <= nxt_type1;
         cfg_bus_ff <= cfg_addr[`PBR_BUS_MSB:`PBR_BUS_LSB];
         cfg_dev_ff <= cfg_addr[`PBR_DEV_MSB:`PBR_DEV_LSB];
      end
   end

   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   sequence s_reissue;
      state_ff == pbr_pkg::S_ADDR ##1 tgt_addr_phase_ff;
   endsequence
   addr_reuse_a: assert property (tgt_addr_phase_ff |-> tgt_addr_ff == q_addr_ff[0]
      && tgt_cmd_ff == q_cmd_ff[0]) else $error("target read address differs from head");
   pref_be_a: assert property (tgt_frame_ff && q_pref_ff[0] |-> tgt_be_ff == 4'h0)
      else $error("prefetch byte enables not all active");
   retry_loop_a: assert property (state_ff == pbr_pkg::S_DATA && tgt_retry && !got_ff
      && !tgt_err && !tgt_stop && tries_ff != 25'(MAX_TRIES) |=> s_reissue)
      else $error("retried read not reissued");
   no_refetch_a: assert property (state_ff == pbr_pkg::S_DONE |-> !tgt_frame_ff
      && !tgt_addr_phase_ff) else $error("refetch after disconnect");
   giveup_serr_a: assert property (giveup |=> serr_ff == $past(serr_en)
      ##1 !serr_ff) else $error("system error wrong on give up");
   one_per_clk_a: assert property (push && !deliver && !clr |=>
      cnt_ff == $past(cnt_ff) + BW'(1)) else $error("read data not taken");
   last_disc_a: assert property (ini_stop_ff |-> ini_trdy_ff && cnt_ff == '0)
      else $error("disconnect not with last data");
   discard_a: assert property (expire |=> state_ff == pbr_pkg::S_IDLE && cnt_ff == '0
      && q_cnt_ff == $past(q_cnt_ff) - QW'(1) + QW'($past(nxt_posted)))
      else $error("expired read not dropped");
   dup_block_a: assert property (new_valid && dup_hit != '0 |=> new_dup_ff
      && !new_posted_ff) else $error("duplicate read posted");
   cfg_sec_a: assert property (cfg_secondary |=> !cfg_devsel_ff)
      else $error("secondary config claimed");
endmodule

// [pbr_target_model.sv]
`timescale 1ns/1ps
module pbr_target_model #(
   parameter logic [31:0] KEY = 32'h5a5a0000
) (
   input  wire logic        sys_clk,
   input  wire logic        reset_n,
   input  wire logic        tgt_frame_ff,
   input  wire logic        tgt_addr_phase_ff,
   input  wire logic [31:0] tgt_addr_ff,
   input  wire logic [31:0] retries,
   output logic             tgt_devsel,
   output logic             tgt_trdy,
   output logic             tgt_retry,
   output logic             tgt_stop,
   output logic             tgt_err,
   output logic [31:0]      tgt_data
);
   logic [31:0] used;
   logic [31:0] nxt_addr;

   assign tgt_stop = 1'b0;
   assign tgt_err  = 1'b0;

   // Idle data lines flip every cycle so a stale word can never look like a fresh one
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         used       <= 32'h0;
         nxt_addr   <= 32'h0;
         tgt_devsel <= 1'b0;
         tgt_trdy   <= 1'b0;
         tgt_retry  <= 1'b0;
         tgt_data   <= 32'h0;
      end else if (tgt_addr_phase_ff && used < retries) begin
         used       <= used + 32'h1;
         tgt_devsel <= 1'b1;
         tgt_trdy   <= 1'b0;
         tgt_retry  <= 1'b1;
         tgt_data   <= ~tgt_data;
      end else if (tgt_addr_phase_ff || (tgt_frame_ff && tgt_trdy)) begin
         used       <= 32'h0;
         nxt_addr   <= (tgt_addr_phase_ff ? tgt_addr_ff : nxt_addr) + 32'h4;
         tgt_data   <= (tgt_addr_phase_ff ? tgt_addr_ff : nxt_addr) ^ KEY;
         tgt_devsel <= 1'b1;
         tgt_trdy   <= 1'b1;
         tgt_retry  <= 1'b0;
      end else begin
         tgt_devsel <= 1'b0;
         tgt_trdy   <= 1'b0;
         tgt_retry  <= 1'b0;
         tgt_data   <= ~tgt_data;
      end
   end
endmodule

// [pbr_delayed_read_tb_top.sv]
`timescale 1ns/1ps
module pbr_delayed_read_tb_top;
   localparam logic [31:0] KEY   = 32'h5a5a0000;
   localparam int          TRIES = 4;
   localparam int          LIMIT = 20000;
   logic        sys_clk, reset_n, new_valid, new_pref, new_posted_ff, new_dup_ff, new_full_ff;
   logic        posted_empty, order_ok, serr_en, tmo_short, tgt_devsel, tgt_trdy, tgt_retry;
   logic        tgt_stop, tgt_err, tgt_frame_ff, tgt_addr_phase_ff, ini_valid, ini_last;
   logic        ini_trdy_ff, ini_stop_ff, ini_retry_ff, ini_abort_ff, flow_ff, serr_ff;
   logic        cfg_valid, cfg_idsel, cfg_secondary, cfg_devsel_ff, cfg_stop_ff, cfg_type1_ff;
   logic        stp, abt, flo;
   logic [3:0]  new_cmd, new_be, tgt_cmd_ff, tgt_be_ff, ini_cmd, cfg_cmd, exp_cmd, exp_be;
   logic [7:0]  cls, cfg_bus_ff;
   logic [4:0]  cfg_dev_ff;
   logic [31:0] new_addr, tgt_data, tgt_addr_ff, ini_addr, ini_data_ff, cfg_addr, exp_addr;
   logic [31:0] retries, ra, rb, rc;
   int          num_errors, cmp_count, cycles, n_addr, serr_seen, seed, got;

   pbr_delayed_read #(.MAX_TRIES(TRIES), .DISC_LONG(20), .DISC_SHORT(5)) i_pbr_delayed_read (
      .sys_clk, .reset_n, .new_valid, .new_addr, .new_cmd, .new_be, .new_pref, .new_posted_ff,
      .new_dup_ff, .new_full_ff, .posted_empty, .order_ok, .cls, .serr_en, .tmo_short,
      .tgt_devsel, .tgt_trdy, .tgt_retry, .tgt_stop, .tgt_err, .tgt_data, .tgt_frame_ff,
      .tgt_addr_phase_ff, .tgt_addr_ff, .tgt_cmd_ff, .tgt_be_ff, .ini_valid, .ini_addr,
      .ini_cmd, .ini_last, .ini_trdy_ff, .ini_data_ff, .ini_stop_ff, .ini_retry_ff,
      .ini_abort_ff, .flow_ff, .serr_ff, .cfg_valid, .cfg_cmd, .cfg_addr, .cfg_idsel,
      .cfg_secondary, .cfg_devsel_ff, .cfg_stop_ff, .cfg_type1_ff, .cfg_bus_ff, .cfg_dev_ff);

   pbr_target_model #(.KEY(KEY)) i_pbr_target_model (
      .sys_clk, .reset_n, .tgt_frame_ff, .tgt_addr_phase_ff, .tgt_addr_ff, .retries,
      .tgt_devsel, .tgt_trdy, .tgt_retry, .tgt_stop, .tgt_err, .tgt_data);

   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
      cmp_count++;
      if (exp !== seen) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic push(input logic [31:0] a, input logic [3:0] c, input logic [3:0] be,
                       input logic pf, input logic [2:0] exp);
      @(posedge sys_clk);
      new_valid <= 1'b1;
      new_addr  <= a;
      new_cmd   <= c;
      new_be    <= be;
      new_pref  <= pf;
      @(posedge sys_clk);
      new_valid <= 1'b0;
      #1;
      chk("new_answer", {29'h0, exp}, {29'h0, new_full_ff, new_dup_ff, new_posted_ff});
   endtask

   task automatic cfg_acc(input logic [31:0] r);
      logic cl;
      logic dev;
      logic t1;
      @(posedge sys_clk);
      cfg_valid     <= 1'b1;
      cfg_addr      <= r;
      cfg_secondary <= r[31];
      cfg_idsel     <= r[30];
      cfg_cmd       <= r[29] ? 4'h6 : (r[28] ? 4'hb : 4'ha);
      @(posedge sys_clk);
      cfg_valid <= 1'b0;
      #1;
      cl  = !r[29];
      dev = cl && !r[31] && r[30] && r[1:0] == 2'b00;
      t1  = cl && r[1:0] == 2'b01;
      chk("cfg_devsel", {31'h0, dev}, {31'h0, cfg_devsel_ff});
      chk("cfg_stop", {31'h0, dev}, {31'h0, cfg_stop_ff});
      chk("cfg_type1", {31'h0, t1}, {31'h0, cfg_type1_ff});
      if (t1) begin
         chk("cfg_busdev", {19'h0, r[23:11]}, {19'h0, cfg_bus_ff, cfg_dev_ff});
      end
   endtask

   // Repeats the read through retries, as a retried initiator must
   task automatic ini_read(input logic [31:0] a, input logic [3:0] c, input int n,
                           input int lim);
      got = 0;
      stp = 1'b0;
      abt = 1'b0;
      flo = 1'b0;
      @(posedge sys_clk);
      ini_valid <= 1'b1;
      ini_addr  <= a;
      ini_cmd   <= c;
      ini_last  <= (n == 1);
      for (int k = 0; k < lim && got < n && !abt; k++) begin
         @(posedge sys_clk);
         #1;
         flo = flo | (flow_ff === 1'b1);
         if (ini_trdy_ff === 1'b1) begin
            chk("ini_data", (a + 32'(4 * got)) ^ KEY, ini_data_ff);
            got++;
            stp = ini_stop_ff;
         end
         abt      = (ini_abort_ff === 1'b1);
         ini_last <= (got == n - 1);
      end
      ini_valid <= 1'b0;
      ini_last  <= 1'b0;
   endtask

   always @(posedge sys_clk) begin
      if (serr_ff === 1'b1) serr_seen++;
      if (tgt_addr_phase_ff === 1'b1) begin
         n_addr++;
         chk("tgt_addr", exp_addr, tgt_addr_ff);
         chk("tgt_cmd", {28'h0, exp_cmd}, {28'h0, tgt_cmd_ff});
         chk("tgt_be", {28'h0, exp_be}, {28'h0, tgt_be_ff});
      end
      cycles++;
      if (cycles == LIMIT) begin
         num_errors++;
         finish_test();
      end
   end

   initial begin
      {new_valid, new_pref, posted_empty, serr_en, tmo_short, ini_valid, ini_last} = 7'h00;
      {cfg_valid, cfg_idsel, cfg_secondary} = 3'h0;
      {new_addr, new_cmd, new_be, ini_addr, ini_cmd, cfg_addr, cfg_cmd} = '0;
      {exp_addr, exp_cmd, exp_be, retries, cls} = '0;
      order_ok = 1'b1;
      seed     = 62;
      reset_n  = 1'b0;
      repeat (20) @(posedge sys_clk);
      reset_n <= 1'b1;
      // Hand-picked claim, write, secondary and type 1 cases, then random ones
      for (int i = 0; i < 28; i++) begin
         case (i)
            0: ra = 32'h40000700;
            1: ra = 32'h50000000;
            2: ra = 32'hc0000000;
            3: ra = 32'h00abf801;
            default: ra = $random(seed);
         endcase
         cfg_acc(ra);
      end
      $display("test config done");
      ra = $random(seed) & 32'hfffffffc;
      // Bits 11:8 cleared so the flow-through burst never meets a 4 KB boundary
      rb = ($random(seed) & 32'hfffff0f0) | 32'h4;
      rc = ($random(seed) & 32'hffffffc0) | 32'h38;
      rd_setup(ra, 4'h6, ra[7:4]);
      push(ra, 4'h6, exp_be, 1'b0, 3'b001);
      push(ra, 4'h6, exp_be, 1'b0, 3'b010);
      push(rb, 4'he, 4'h5, 1'b1, 3'b001);
      push(rc, 4'h6, 4'h3, 1'b1, 3'b001);
      push(rc ^ 32'h1000, 4'h6, 4'h0, 1'b1, 3'b100);
      repeat (8) @(posedge sys_clk);
      chk("addr_phases", 0, n_addr);
      retries      <= 32'h2;
      cls          <= 8'h4;
      posted_empty <= 1'b1;
      ini_read(ra, 4'hc, 1, 60);
      chk("got", 1, got);
      chk("stop", 1, {31'h0, stp});
      chk("addr_phases", 3, n_addr);
      rd_setup(rb, 4'he, 4'h0);
      retries <= 32'h0;
      ini_read(rb, 4'h6, 3, 60);
      // Repeat arrives while the fetch runs, so this one streams and the initiator ends it
      chk("got", 3, got);
      chk("stop", 0, {31'h0, stp});
      chk("flow", 1, {31'h0, flo});
      chk("frame", 0, {31'h0, tgt_frame_ff});
      rd_setup(rc, 4'h6, 4'h0);
      cls <= 8'h3;
      ini_read(rc, 4'h6, 1, 60);
      chk("got", 1, got);
      chk("flow", 0, {31'h0, flo});
      $display("test queue done");
      ra = $random(seed) & 32'hfffffffc;
      rd_setup(ra, 4'h6, 4'h9);
      retries   <= 32'hffffffff;
      serr_en   <= 1'b1;
      serr_seen = 0;
      n_addr    = 0;
      push(ra, 4'h6, 4'h9, 1'b0, 3'b001);
      ini_read(ra, 4'h6, 1, 80);
      repeat (2) @(posedge sys_clk);
      chk("abort", 1, {31'h0, abt});
      chk("addr_phases", TRIES, n_addr);
      chk("serr", 1, serr_seen);
      $display("test give up done");
      retries <= 32'h0;
      serr_en <= 1'b0;
      for (int t = 0; t < 2; t++) begin
         ra = $random(seed) & 32'hfffffffc;
         rd_setup(ra, 4'h6, ra[5:2]);
         tmo_short <= t[0];
         push(ra, 4'h6, exp_be, 1'b0, 3'b001);
         repeat (16) @(posedge sys_clk);
         ini_read(ra, 4'h6, 1, 8);
         chk("got", (t == 1) ? 0 : 1, got);
         chk("retry", (t == 1) ? 1 : 0, {31'h0, ini_retry_ff});
      end
      $display("test discard done");
      finish_test();
   end

   task automatic rd_setup(input logic [31:0] a, input logic [3:0] c, input logic [3:0] be);
      exp_addr = a;
      exp_cmd  = c;
      exp_be   = be;
   endtask
endmodule
